/* File: rtl/tsr_frontend.sv */
`timescale 1ns/10ps
`include "tsr_regs.svh"
module tsr_frontend
  import tsr_pkg::*;
#(
  parameter int CLK_PER_MS = `TSR_CLK_HZ / `TSR_TB_HZ
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Receiver module pins.
  input wire logic rx_pin_in,
  output logic pullup_enable,
  output logic receiver_power_save_output,
  // Indicator and timebase pins.
  output logic rx_led,
  output logic timebase_output,
  // Configuration.
  input wire logic analyse_en,
  input wire tsr_pkg::tsr_pol_mode_type pol_mode,
  input wire tsr_pkg::tsr_pull_mode_type pull_mode,
  input wire logic ps_active_high,
  input wire logic signed [7:0] cal_trim,
  // Status and decoded minute.
  output logic pol_inverted,
  output logic pullup_needed,
  output tsr_pkg::tsr_state_type rx_state,
  output logic bit_error,
  output logic minute_valid,
  output logic [`TSR_BITS_PER_MIN-1:0] minute_data
);

  import tsr_pkg::*;

  function automatic tsr_bit_type classify(input logic [11:0] ms);
    if (ms >= 12'(`TSR_ZERO_MIN_MS) && ms <= 12'(`TSR_ZERO_MAX_MS)) begin
      return TSR_BIT_ZERO;
    end else if (ms >= 12'(`TSR_ONE_MIN_MS) && ms <= 12'(`TSR_ONE_MAX_MS)) begin
      return TSR_BIT_ONE;
    end
    return TSR_BIT_NONE;
  endfunction

  tsr_tb_if tbi ();
  assign tbi.trim = cal_trim;

  tsr_timebase #(
    .CLK_PER_MS(CLK_PER_MS)
  ) u_timebase (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tb(tbi),
    .timebase_output(timebase_output)
  );

  // Pin synchroniser; only the second stage and later are looked at.
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic [11:0] run_ms;
  logic [5:0] probe_ms;
  logic probe_toggle;
  logic auto_inv;
  logic [5:0] bit_cnt;
  logic [`TSR_BITS_PER_MIN-1:0] shift;
  tsr_state_type state;
  tsr_state_type next_state;

  wire ms_tick = tbi.ms_tick;
  wire edge_seen = rx_sync ^ rx_prev;
  wire tsr_bit_type run_class = classify(run_ms);
  wire run_valid = (run_class != TSR_BIT_NONE);
  wire next_inv = (pol_mode == TSR_POL_INV) | ((pol_mode == TSR_POL_AUTO) & auto_inv);
  wire active_end = edge_seen & (rx_prev == ~pol_inverted);
  wire gap_end = edge_seen & (rx_prev == pol_inverted) & (run_ms >= 12'(`TSR_MARKER_MS));
  wire probing = (pull_mode == TSR_PULL_AUTO) & (probe_ms != 6'(`TSR_PROBE_MS));
  wire minute_full = (bit_cnt == 6'(`TSR_BITS_PER_MIN));

  assign rx_state = state;

  always_comb begin
    next_state = state;
    unique case (state)
      TSR_ST_IDLE: begin
        if (analyse_en) begin
          next_state = TSR_ST_SEARCH;
        end
      end
      TSR_ST_SEARCH: begin
        if (gap_end) begin
          next_state = TSR_ST_READ;
        end
      end
      TSR_ST_READ: begin
        if (active_end && !run_valid) begin
          next_state = TSR_ST_SEARCH;
        end else if (bit_cnt > 6'(`TSR_BITS_PER_MIN)) begin
          next_state = TSR_ST_SEARCH;
        end
      end
    endcase
    if (!analyse_en) begin
      next_state = TSR_ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      rx_prev <= 1'b0;
      run_ms <= 12'h000;
    end else begin
      rx_meta <= rx_pin_in;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
      if (edge_seen) begin
        run_ms <= 12'h000;
      end else if (ms_tick && run_ms != 12'hFFF) begin
        run_ms <= run_ms + 12'h001;
      end
    end
  end

  // A level run of valid pulse length marks that level as the active one.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      auto_inv <= 1'b0;
      pol_inverted <= 1'b0;
    end else begin
      if (edge_seen && run_valid && state != TSR_ST_IDLE) begin
        auto_inv <= ~rx_prev;
      end
      pol_inverted <= next_inv;
    end
  end

  // In auto mode the pull-up stays off while idle and briefly after analysis starts; a driven output toggles.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      probe_ms <= 6'h00;
      probe_toggle <= 1'b0;
      pullup_needed <= 1'b1;
      pullup_enable <= 1'b0;
    end else begin
      if (state == TSR_ST_IDLE) begin
        probe_ms <= 6'h00;
        probe_toggle <= 1'b0;
      end else if (probing) begin
        probe_ms <= ms_tick ? probe_ms + 6'h01 : probe_ms;
        probe_toggle <= probe_toggle | edge_seen;
        if (ms_tick && probe_ms == 6'(`TSR_PROBE_MS - 1)) begin
          pullup_needed <= ~(probe_toggle | edge_seen);
        end
      end
      unique case (pull_mode)
        TSR_PULL_ON: pullup_enable <= 1'b1;
        TSR_PULL_OFF: pullup_enable <= 1'b0;
        default: pullup_enable <= pullup_needed & ~probing;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      receiver_power_save_output <= 1'b0;
      rx_led <= 1'b0;
    end else begin
      receiver_power_save_output <= analyse_en ? ps_active_high : ~ps_active_high;
      rx_led <= (state != TSR_ST_IDLE) & (rx_sync ^ pol_inverted);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= TSR_ST_IDLE;
      bit_cnt <= 6'h00;
      shift <= '0;
      bit_error <= 1'b0;
      minute_valid <= 1'b0;
      minute_data <= '0;
    end else begin
      state <= next_state;
      minute_valid <= 1'b0;
      bit_error <= (state == TSR_ST_READ) & active_end & ~run_valid;
      if (next_state != TSR_ST_READ || state != TSR_ST_READ) begin
        bit_cnt <= 6'h00;
      end else if (gap_end) begin
        bit_cnt <= 6'h00;
        if (minute_full) begin
          minute_valid <= 1'b1;
          minute_data <= shift;
        end
      end else if (active_end) begin
        bit_cnt <= bit_cnt + 6'h01;
        shift <= {run_class == TSR_BIT_ONE, shift[`TSR_BITS_PER_MIN-1:1]};
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_ps_on;
    analyse_en |=> receiver_power_save_output == ps_active_high;
  endproperty
  a_ps_on: assert property (p_ps_on) else $error("Power output not on during analysis.");

  property p_ps_off;
    !analyse_en [*2] |-> receiver_power_save_output != ps_active_high && state == TSR_ST_IDLE;
  endproperty
  a_ps_off: assert property (p_ps_off) else $error("Power output on outside analysis.");

  property p_led_idle;
    state == TSR_ST_IDLE |=> !rx_led;
  endproperty
  a_led_idle: assert property (p_led_idle) else $error("Indicator lit while idle.");

  property p_pol_forced;
    pol_mode == TSR_POL_INV [*2] |-> pol_inverted;
  endproperty
  a_pol_forced: assert property (p_pol_forced) else $error("Forced inverting polarity ignored.");

  property p_pull_forced;
    pull_mode == TSR_PULL_OFF |=> !pullup_enable;
  endproperty
  a_pull_forced: assert property (p_pull_forced) else $error("Pull-up on while forced off.");

  property p_minute_count;
    minute_valid |-> $past(bit_cnt) == 6'(`TSR_BITS_PER_MIN) && $past(gap_end);
  endproperty
  a_minute_count: assert property (p_minute_count) else $error("Minute presented without full count.");

  property p_bad_pulse;
    state == TSR_ST_READ && analyse_en && active_end && !run_valid |=> state == TSR_ST_SEARCH && bit_error;
  endproperty
  a_bad_pulse: assert property (p_bad_pulse) else $error("Out of window pulse not rejected.");

endmodule

/* File: rtl/tsr_regs.svh */
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

// System clock rate and timebase rate, in hertz.
`define TSR_CLK_HZ 40000000
`define TSR_TB_HZ 1000
// Cycles added to the timebase period per calibration step.
`define TSR_TRIM_STEP 4
// Nominal pulse lengths, in milliseconds.
`define TSR_ZERO_MS 100
`define TSR_ONE_MS 200
// Acceptance windows around the nominal pulse lengths, in milliseconds.
`define TSR_ZERO_MIN_MS 70
`define TSR_ZERO_MAX_MS 130
`define TSR_ONE_MIN_MS 170
`define TSR_ONE_MAX_MS 250
// Inactive gap that marks the missing pulse of the last second, in milliseconds.
`define TSR_MARKER_MS 1500
// Time the pull-up stays off after analysis starts to probe the output type.
`define TSR_PROBE_MS 50
// Data pulses between two minute markers (one minute of 60 seconds).
`define TSR_BITS_PER_MIN 59
// Reset values.
`define TSR_RST_TRIM 8'h00

`endif

/* File: rtl/tsr_pkg.sv */
package tsr_pkg;

  typedef enum logic [2:0] {
    TSR_ST_IDLE = 3'b001,
    TSR_ST_SEARCH = 3'b010,
    TSR_ST_READ = 3'b100
  } tsr_state_type;

  typedef enum logic [1:0] {
    TSR_POL_AUTO = 2'h0,
    TSR_POL_NONINV = 2'h1,
    TSR_POL_INV = 2'h2
  } tsr_pol_mode_type;

  typedef enum logic [1:0] {
    TSR_PULL_AUTO = 2'h0,
    TSR_PULL_ON = 2'h1,
    TSR_PULL_OFF = 2'h2
  } tsr_pull_mode_type;

  typedef enum logic [1:0] {
    TSR_BIT_NONE = 2'h0,
    TSR_BIT_ZERO = 2'h1,
    TSR_BIT_ONE = 2'h2
  } tsr_bit_type;

endpackage

/* File: rtl/tsr_tb_if.sv */
`timescale 1ns/10ps
interface tsr_tb_if;
  logic signed [7:0] trim;
  logic ms_tick;
  modport src (input trim, output ms_tick);
  modport snk (output trim, input ms_tick);
endinterface

/* File: rtl/tsr_timebase.sv */
`timescale 1ns/10ps
`include "tsr_regs.svh"
module tsr_timebase #(
  parameter int CLK_PER_MS = `TSR_CLK_HZ / `TSR_TB_HZ
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Trim in, millisecond tick out.
  tsr_tb_if.src tb,
  // Square timebase pin.
  output logic timebase_output
);

  // Period in cycles after applying the signed calibration trim.
  function automatic logic [19:0] calc_period(input logic signed [7:0] trim);
    int p;
    p = CLK_PER_MS + int'(trim) * `TSR_TRIM_STEP;
    return p[19:0];
  endfunction

  logic [19:0] cnt;
  logic ms_tick;
  wire [19:0] period = calc_period(tb.trim);
  wire [19:0] half_hi = {1'b0, period[19:1]};
  wire [19:0] half_lo = period - half_hi;
  wire phase_end = (cnt == 20'h00000);

  assign tb.ms_tick = ms_tick;

  // The trim shifts both the pin frequency and the tick that paces all timekeeping.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt <= 20'h00000;
      timebase_output <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= phase_end & timebase_output;
      if (phase_end) begin
        timebase_output <= ~timebase_output;
        cnt <= timebase_output ? half_lo - 20'h00001 : half_hi - 20'h00001;
      end else begin
        cnt <= cnt - 20'h00001;
      end
    end
  end

  // Helper: cycles since the last tick, for checking the trimmed period.
  // A trim change inside the measured span mixes two periods, so such spans are skipped.
  logic [19:0] since;
  logic tick_seen;
  logic signed [7:0] trim_prev;
  logic trim_moved;
  wire trim_step = (tb.trim != trim_prev);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      since <= 20'h00000;
      tick_seen <= 1'b0;
      trim_prev <= 8'sh00;
      trim_moved <= 1'b1;
    end else begin
      since <= ms_tick ? 20'h00001 : since + 20'h00001;
      tick_seen <= tick_seen | ms_tick;
      trim_prev <= tb.trim;
      trim_moved <= ms_tick ? trim_step : (trim_moved | trim_step);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_tick_period;
    ms_tick && tick_seen && !trim_moved && !trim_step |-> since == period;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("Tick spacing differs from trimmed period.");

  property p_square_edge;
    $changed(timebase_output) |-> $past(cnt) == 20'h00000;
  endproperty
  a_square_edge: assert property (p_square_edge) else $error("Timebase toggled mid phase.");

endmodule

/* File: test/tsr_rx_model.sv */
`timescale 1ns/10ps
module tsr_rx_model #(
  parameter int MS_NS = 50
) (
  // Supply and output sense.
  input wire logic powered,
  input wire logic inverted,
  // Pulse pin.
  output logic rx_pin
);
  logic act = 1'b0;
  logic junk = 1'b0;
  // An unpowered receiver gives no defined level, so the line wanders.
  always #10 junk = ~junk;
  assign rx_pin = powered ? (act ^ inverted) : junk;
  task automatic pulse(input int on_ms, input int off_ms);
    act = 1'b1;
    #(on_ms * MS_NS);
    act = 1'b0;
    #(off_ms * MS_NS);
  endtask
endmodule

/* File: test/tb_tsr_frontend.sv */
`timescale 1ns/10ps
`include "tsr_regs.svh"
module tb_tsr_frontend;
  import tsr_pkg::*;
  localparam int CPM = 2;
  localparam int MS = CPM * 25;
  logic sys_clk = 1'b0, nrst = 1'b0, analyse_en = 1'b0, ps_active_high = 1'b0, inv = 1'b0;
  tsr_pol_mode_type pol_mode = TSR_POL_AUTO;
  tsr_pull_mode_type pull_mode = TSR_PULL_AUTO;
  logic signed [7:0] cal_trim = 8'sh00;
  logic rx_pin_in, pullup_enable, receiver_power_save_output, rx_led, timebase_output;
  logic pol_inverted, pullup_needed, bit_error, minute_valid;
  tsr_state_type rx_state;
  logic [`TSR_BITS_PER_MIN-1:0] minute_data, bits;
  logic [63:0] exp_q[$];
  int n_errors = 0, comparisons = 0, cycles = 0, t, b;
  realtime t0;

  initial forever #12.5 sys_clk = ~sys_clk;

  tsr_frontend #(.CLK_PER_MS(CPM)) u_tsr_frontend (
    .sys_clk(sys_clk), .nrst(nrst), .rx_pin_in(rx_pin_in), .pullup_enable(pullup_enable),
    .receiver_power_save_output(receiver_power_save_output), .rx_led(rx_led),
    .timebase_output(timebase_output), .analyse_en(analyse_en), .pol_mode(pol_mode),
    .pull_mode(pull_mode), .ps_active_high(ps_active_high), .cal_trim(cal_trim),
    .pol_inverted(pol_inverted), .pullup_needed(pullup_needed), .rx_state(rx_state),
    .bit_error(bit_error), .minute_valid(minute_valid), .minute_data(minute_data)
  );

  tsr_rx_model #(.MS_NS(MS)) u_tsr_rx_model (
    .powered(receiver_power_save_output == ps_active_high), .inverted(inv), .rx_pin(rx_pin_in)
  );

  task automatic cmp(input logic [63:0] got, input logic [63:0] expv);
    comparisons++;
    if (got !== expv) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, expv);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Measures one full timebase period in clock cycles after a reload.
  task automatic period(input int expv);
    @(posedge timebase_output);
    @(posedge timebase_output);
    t0 = $realtime;
    @(posedge timebase_output);
    cmp(64'(int'(($realtime - t0) / 25.0)), 64'(expv));
    tick(1);
  endtask

  // Each decoded minute or refused pulse is matched against the oldest note.
  always @(negedge sys_clk) begin
    if (minute_valid === 1'b1 || bit_error === 1'b1) begin
      if (exp_q.size() == 0) cmp(64'(1), 64'(0));
      else cmp(64'({bit_error, bit_error ? 59'h0 : minute_data}), exp_q.pop_front());
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    t = $urandom(57865);
    tick(8);
    nrst = 1'b1;
    tick(2);
    cmp(64'(receiver_power_save_output), 64'(1));
    cmp(64'(pullup_needed), 64'(1));
    period(CPM);
    t = $urandom_range(7);
    cal_trim = 8'(t);
    period(CPM + 4 * t);
    // The trim also paces the millisecond tick, so pulse timing needs it back at zero.
    cal_trim = 8'sh00;
    period(CPM);
    ps_active_high = 1'($urandom_range(1));
    inv = 1'($urandom_range(1));
    analyse_en = 1'b1;
    tick(2);
    cmp(64'(receiver_power_save_output), 64'(ps_active_high));
    // The first edge lands inside the probe time, so no pull-up is wanted.
    #(20 * MS);
    u_tsr_rx_model.pulse(100, 300);
    cmp(64'(pol_inverted), 64'(inv));
    cmp(64'(pullup_needed), 64'(0));
    cmp(64'(pullup_enable), 64'(0));
    // The indicator follows the pulses only once the polarity has been learnt.
    fork
      u_tsr_rx_model.pulse(200, 300);
      begin
        #(50 * MS);
        cmp(64'(rx_led), 64'(1));
        #(200 * MS);
        cmp(64'(rx_led), 64'(0));
      end
    join
    #(1600 * MS);
    bits = 59'({$urandom(), $urandom()});
    for (b = 0; b < 59; b++) begin
      u_tsr_rx_model.pulse(bits[b] ? 200 : 100, 300);
      if (b == 0) cmp(64'(rx_state), 64'(TSR_ST_READ));
    end
    exp_q.push_back({4'h0, 1'b0, bits});
    #(1600 * MS);
    u_tsr_rx_model.pulse(100, 300);
    cmp(64'(exp_q.size()), 64'(0));
    exp_q.push_back({4'h0, 1'b1, 59'h0});
    u_tsr_rx_model.pulse(150, 300);
    cmp(64'(exp_q.size()), 64'(0));
    cmp(64'(rx_state), 64'(TSR_ST_SEARCH));
    pol_mode = TSR_POL_NONINV;
    pull_mode = TSR_PULL_ON;
    tick(2);
    cmp(64'(pol_inverted), 64'(0));
    cmp(64'(pullup_enable), 64'(1));
    pol_mode = TSR_POL_INV;
    pull_mode = TSR_PULL_OFF;
    tick(2);
    cmp(64'(pol_inverted), 64'(1));
    cmp(64'(pullup_enable), 64'(0));
    analyse_en = 1'b0;
    tick(2);
    cmp(64'(receiver_power_save_output), 64'(!ps_active_high));
    cmp(64'(rx_state), 64'(TSR_ST_IDLE));
    cmp(64'(rx_led), 64'(0));
    wrap_up();
  end
endmodule
